/* File: verilog/fattr_pkg.sv */
// constants, carriers and encodings for the file attribute / status decoder
// assumes a single 20 MHz clock; all inputs synchronous to it
//=============================================================
// Contract
// - no reference object: reference is low five bits of file identifier.
// - reference object with zero length: short reference addressing unsupported.
// - one-byte reference sits in bits 8..4; low three bits must be zero.
// - life cycle byte reported in object tag 8A, length one.
// - 00 no info, 01 creation, 03 initialization, upper nibble nonzero proprietary.
// - operational: bit3 set, upper five clear; bit1 activated; bit2 ignored.
// - pin template tag C6, first member tag 90 holding enable bitmap.
// - key references tag 83 length one follow, optional qualifier tag 95.
// - qualifier always emitted before key reference 11 (universal pin).
// - qualifier immediately precedes its key reference; value tells verification use.
// - each bitmap bit enables the key reference in template order.
// - key reference count equals number of distinct pins in use.
// - status first parameter 01: terminal finished session activation.
// - status first parameter 02: termination begins; 00 no indication.
// - second parameter 00 control params, 01 name, 0C none, else reserved.
// - binary read runs only when read access condition is satisfied.
// - binary read returns count bytes from given offset.
// - p1 top bit clear: offset high; top bits 100: short reference.
package fattr_pkg;
  localparam logic [7:0] TAG_SHORT_REF = 8'h88;
  localparam logic [7:0] TAG_LIFE = 8'h8A;
  localparam logic [7:0] TAG_PIN_TMPL = 8'hC6;
  localparam logic [7:0] TAG_PIN_EN = 8'h90;
  localparam logic [7:0] TAG_QUAL = 8'h95;
  localparam logic [7:0] TAG_KEYREF = 8'h83;
  localparam logic [7:0] LEN_ONE = 8'h01;
  localparam logic [7:0] KEY_UNIVERSAL = 8'h11;
  localparam logic [7:0] QUAL_VERIFY = 8'h08;
  localparam logic [7:0] QUAL_NONE = 8'h00;
  localparam logic [7:0] P1_NONE = 8'h00;
  localparam logic [7:0] P1_ACTIVATED = 8'h01;
  localparam logic [7:0] P1_TERMINATE = 8'h02;
  localparam logic [7:0] P2_FCP = 8'h00;
  localparam logic [7:0] P2_NAME = 8'h01;
  localparam logic [7:0] P2_NODATA = 8'h0C;
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [15:0] SW_BAD_PARAM = 16'h6B00;
  localparam logic [15:0] SW_DENIED = 16'h6982;
  localparam int MAX_PINS = 8;
  // life cycle classes
  typedef enum logic [2:0] {
    LC_NOINFO = 3'h0, LC_CREATE = 3'h1, LC_INIT = 3'h2, LC_OP_ACT = 3'h3,
    LC_OP_DEACT = 3'h4, LC_TERM = 3'h5, LC_PROP = 3'h6, LC_RFU = 3'h7
  } life_t;
  // status command response selection
  typedef enum logic [1:0] {RSP_FCP = 2'h0, RSP_NAME = 2'h1, RSP_NONE = 2'h2, RSP_ERR = 2'h3} rsp_t;
  // pin entry: key reference, verification use, qualifier present
  typedef struct packed {
    logic [7:0] key;
    logic verify;
    logic qual_present;
  } pin_entry_t;
  // command header
  typedef struct packed {
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] le;
  } cmd_t;
endpackage

/* File: verilog/life_decode.sv */
// combinational life cycle byte classifier
// assumes byte is stable when sampled by the caller
`timescale 1ns/100ps
module life_decode
  import fattr_pkg::*;
(
  // value in
  input wire logic [7:0] lcsi_in,
  // class out
  output life_t class_out
);
  wire upper_clear = (lcsi_in[7:4] == 4'h0);
  wire op_form = (lcsi_in[7:2] == 6'h01);
  wire term_form = upper_clear && (lcsi_in[3:2] == 2'h3);
  //=============================================================
  // classification; termination checked before operational
  assign class_out = (lcsi_in == 8'h00) ? LC_NOINFO :
                     (lcsi_in == 8'h01) ? LC_CREATE :
                     (lcsi_in == 8'h03) ? LC_INIT :
                     !upper_clear ? LC_PROP :
                     term_form ? LC_TERM :
                     (op_form && lcsi_in[0]) ? LC_OP_ACT :
                     op_form ? LC_OP_DEACT : LC_RFU;
endmodule // life_decode

/* File: verilog/fattr_status_dec.sv */
// file attribute, status command and binary read decoder (top)
// assumes command strobes are one-cycle pulses synchronous to clk_in
`timescale 1ns/100ps
module fattr_status_dec
  import fattr_pkg::*;
#(
  parameter int NPINS = MAX_PINS
)(
  // clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // selected file attributes
  input wire logic [15:0] file_id_in,
  input wire logic sref_present_in,
  input wire logic [7:0] sref_len_in,
  input wire logic [7:0] sref_val_in,
  input wire logic [7:0] lcsi_in,
  // pin configuration
  input wire logic [7:0] pin_enable_map_in,
  input wire logic [3:0] pin_count_in,
  input wire logic [NPINS*8-1:0] pin_keys_in,
  input wire logic [NPINS-1:0] pin_verify_in,
  // commands
  input wire logic status_req_in,
  input wire logic read_req_in,
  input wire logic pin_tmpl_req_in,
  input wire logic life_req_in,
  input wire cmd_t cmd_in,
  input wire logic read_allowed_in,
  // file attribute results
  output logic [4:0] short_file_ref_out,
  output logic sref_supported_out,
  output logic sref_malformed_out,
  output life_t life_class_out,
  // status command results
  output logic app_activated_out,
  output logic app_terminating_out,
  output rsp_t status_rsp_out,
  output logic [15:0] status_word_out,
  output logic done_out,
  // binary read results
  output logic read_go_out,
  output logic [14:0] read_offset_out,
  output logic [7:0] read_len_out,
  output logic read_by_sref_out,
  output logic [4:0] read_sref_out,
  // attribute object byte stream
  output logic [7:0] obj_byte_out,
  output logic obj_valid_out,
  output logic [NPINS-1:0] pin_enabled_out
);
  //=============================================================
  // short file reference selection
  wire [4:0] sref_from_id = file_id_in[4:0];
  wire [4:0] sref_from_obj = sref_val_in[7:3];
  wire sref_empty = sref_present_in && (sref_len_in == 8'h00);
  wire sref_bad = sref_present_in && (sref_len_in == 8'h01) && (sref_val_in[2:0] != 3'h0);
  wire [4:0] sref_nxt = sref_present_in ? sref_from_obj : sref_from_id;
  life_t life_nxt;

  life_decode u_life (
    .lcsi_in(lcsi_in),
    .class_out(life_nxt)
  );

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      short_file_ref_out <= 5'h00;
      sref_supported_out <= 1'b0;
      sref_malformed_out <= 1'b0;
      life_class_out <= LC_NOINFO;
    end else begin
      short_file_ref_out <= sref_empty ? 5'h00 : sref_nxt;
      sref_supported_out <= !sref_empty && !sref_bad;
      sref_malformed_out <= sref_bad;
      life_class_out <= life_nxt;
    end
  end

  //=============================================================
  // status command decode
  wire p1_ok = (cmd_in.p1 == P1_NONE) || (cmd_in.p1 == P1_ACTIVATED) || (cmd_in.p1 == P1_TERMINATE);
  wire [1:0] p2_sel = (cmd_in.p2 == P2_FCP) ? RSP_FCP :
                      (cmd_in.p2 == P2_NAME) ? RSP_NAME :
                      (cmd_in.p2 == P2_NODATA) ? RSP_NONE : RSP_ERR;
  wire status_ok = p1_ok && (p2_sel != RSP_ERR);
  // binary read parameter decode
  wire p1_offset_form = !cmd_in.p1[7];
  wire p1_sref_form = (cmd_in.p1[7:5] == 3'h4);
  wire read_ok = read_allowed_in && (p1_offset_form || p1_sref_form);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      app_activated_out <= 1'b0;
      app_terminating_out <= 1'b0;
      status_rsp_out <= RSP_NONE;
      status_word_out <= SW_OK;
      done_out <= 1'b0;
    end else begin
      done_out <= status_req_in || read_req_in;
      app_activated_out <= status_req_in && status_ok && (cmd_in.p1 == P1_ACTIVATED);
      app_terminating_out <= status_req_in && status_ok && (cmd_in.p1 == P1_TERMINATE);
      if (status_req_in) begin
        status_rsp_out <= status_ok ? rsp_t'(p2_sel) : RSP_ERR;
        status_word_out <= status_ok ? SW_OK : SW_BAD_PARAM;
      end else if (read_req_in) begin
        status_word_out <= read_ok ? SW_OK : SW_DENIED;
      end
    end
  end

  // read request launch; bytes counted by the file store
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      read_go_out <= 1'b0;
      read_offset_out <= 15'h0000;
      read_len_out <= 8'h00;
      read_by_sref_out <= 1'b0;
      read_sref_out <= 5'h00;
    end else begin
      read_go_out <= read_req_in && read_ok;
      if (read_req_in && read_ok) begin
        read_offset_out <= p1_offset_form ? {cmd_in.p1[6:0], cmd_in.p2} : {7'h00, cmd_in.p2};
        read_len_out <= cmd_in.le;
        read_by_sref_out <= p1_sref_form;
        read_sref_out <= cmd_in.p1[4:0];
      end
    end
  end

  //=============================================================
  // object emitter: life cycle object or pin template, byte per cycle
  typedef enum logic [2:0] {
    EM_IDLE = 3'h0, EM_HDR = 3'h1, EM_BODY = 3'h3, EM_QUAL = 3'h2, EM_KEY = 3'h6
  } em_t;
  em_t em_r, em_nxt;
  logic [3:0] idx_r;
  logic [2:0] step_r;
  logic is_pin_r;

  function automatic logic [7:0] key_at(input logic [NPINS*8-1:0] keys, input logic [3:0] i);
    key_at = keys[i[2:0]*8 +: 8];
  endfunction

  // the universal pin always carries a qualifier so the terminal can see its use
  function automatic logic qual_needed(input logic [7:0] key, input logic verify);
    qual_needed = (key == KEY_UNIVERSAL) || verify;
  endfunction

  // template length: bitmap object, then three bytes per key and per qualifier
  function automatic logic [7:0] tmpl_size(input logic [NPINS*8-1:0] keys, input logic [NPINS-1:0] verify,
      input logic [3:0] n);
    logic [7:0] sz;
    sz = 8'h03;
    for (int i = 0; i < NPINS; i++) begin
      if (4'(i) < n) begin
        sz = sz + 8'h03;
        if (qual_needed(keys[i*8 +: 8], verify[i])) begin
          sz = sz + 8'h03;
        end
      end
    end
    tmpl_size = sz;
  endfunction

  wire [7:0] cur_key = key_at(pin_keys_in, idx_r);
  wire need_qual = qual_needed(cur_key, pin_verify_in[idx_r[2:0]]);
  wire [3:0] npins = (pin_count_in > 4'(NPINS)) ? 4'(NPINS) : pin_count_in;
  wire [7:0] tmpl_len = tmpl_size(pin_keys_in, pin_verify_in, npins);
  wire last_pin = (idx_r + 4'h1) >= npins;
  wire [3:0] idx_next = idx_r + 4'h1;
  wire need_qual_next = qual_needed(key_at(pin_keys_in, idx_next), pin_verify_in[idx_next[2:0]]);

  // header: tag, length; body: pin object tag, length, bitmap
  logic [7:0] byte_nxt;
  always_comb begin
    byte_nxt = 8'h00;
    em_nxt = em_r;
    unique case (em_r)
      EM_IDLE: em_nxt = (pin_tmpl_req_in || life_req_in) ? EM_HDR : EM_IDLE;
      EM_HDR: begin
        byte_nxt = (step_r == 3'h0) ? (is_pin_r ? TAG_PIN_TMPL : TAG_LIFE) :
                   (is_pin_r ? tmpl_len : LEN_ONE);
        em_nxt = (step_r == 3'h1) ? EM_BODY : EM_HDR;
      end
      EM_BODY: begin
        byte_nxt = !is_pin_r ? lcsi_in :
                   (step_r == 3'h0) ? TAG_PIN_EN : (step_r == 3'h1) ? LEN_ONE : pin_enable_map_in;
        em_nxt = (!is_pin_r || npins == 4'h0) ? ((is_pin_r && step_r != 3'h2) ? EM_BODY : EM_IDLE) :
                 (step_r == 3'h2) ? (need_qual ? EM_QUAL : EM_KEY) : EM_BODY;
      end
      EM_QUAL: begin
        byte_nxt = (step_r == 3'h0) ? TAG_QUAL : (step_r == 3'h1) ? LEN_ONE :
                   (pin_verify_in[idx_r[2:0]] ? QUAL_VERIFY : QUAL_NONE);
        em_nxt = (step_r == 3'h2) ? EM_KEY : EM_QUAL;
      end
      EM_KEY: begin
        byte_nxt = (step_r == 3'h0) ? TAG_KEYREF : (step_r == 3'h1) ? LEN_ONE : cur_key;
        em_nxt = (step_r != 3'h2) ? EM_KEY : last_pin ? EM_IDLE : EM_KEY;
      end
      default: em_nxt = EM_IDLE;
    endcase
  end

  wire step_wrap = ((em_r == EM_HDR) && step_r == 3'h1) || (em_r != EM_HDR && step_r == 3'h2) ||
                   (em_r == EM_BODY && !is_pin_r);
  // next key begins when a key object completes; its qualifier comes first
  wire key_done = (em_r == EM_KEY) && (step_r == 3'h2);

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      em_r <= EM_IDLE;
      step_r <= 3'h0;
      idx_r <= 4'h0;
      is_pin_r <= 1'b0;
    end else begin
      em_r <= (key_done && !last_pin && need_qual_next) ? EM_QUAL : em_nxt;
      step_r <= (em_r == EM_IDLE || step_wrap) ? 3'h0 : step_r + 3'h1;
      if (em_r == EM_IDLE) begin
        idx_r <= 4'h0;
        is_pin_r <= pin_tmpl_req_in;
      end else if (key_done) begin
        idx_r <= idx_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      obj_byte_out <= 8'h00;
      obj_valid_out <= 1'b0;
      pin_enabled_out <= '0;
    end else begin
      obj_byte_out <= byte_nxt;
      obj_valid_out <= (em_r != EM_IDLE);
      pin_enabled_out <= pin_enable_map_in[NPINS-1:0];
    end
  end

  //=============================================================
  // checks
  // short reference
  sref_id_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !sref_present_in |=> short_file_ref_out == $past(file_id_in[4:0])) else $error("sref not from id");
  sref_empty_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    sref_empty |=> !sref_supported_out) else $error("empty sref supported");
  sref_bits_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (sref_present_in && sref_len_in == 8'h01 && sref_val_in[2:0] == 3'h0) |=>
    sref_supported_out && short_file_ref_out == $past(sref_val_in[7:3])) else $error("sref bits");
  // status command, binary read and life cycle object header
  status_act_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (status_req_in && cmd_in == {P1_ACTIVATED, P2_NODATA, 8'h00}) |=> app_activated_out && done_out)
    else $error("activation missed");
  status_term_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (status_req_in && cmd_in.p1 == P1_TERMINATE && cmd_in.p2 == P2_FCP) |=> app_terminating_out)
    else $error("termination missed");
  status_rfu_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (status_req_in && !p1_ok) |=> status_rsp_out == RSP_ERR && status_word_out == SW_BAD_PARAM)
    else $error("reserved accepted");
  read_deny_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (read_req_in && !read_allowed_in) |=> !read_go_out && status_word_out == SW_DENIED)
    else $error("read not refused");
  read_off_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (read_req_in && read_allowed_in && !cmd_in.p1[7]) |=> read_go_out &&
    read_offset_out == {$past(cmd_in.p1[6:0]), $past(cmd_in.p2)} && read_len_out == $past(cmd_in.le))
    else $error("read offset");
  life_tag_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (em_r == EM_IDLE && life_req_in && !pin_tmpl_req_in) |=> ##1 obj_byte_out == TAG_LIFE ##1 obj_byte_out == LEN_ONE)
    else $error("life object header");
  // life cycle decode
  life_op_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (lcsi_in[7:2] == 6'h01) |=> life_class_out == ($past(lcsi_in[0]) ? LC_OP_ACT : LC_OP_DEACT))
    else $error("operational state");
  life_term_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (lcsi_in[7:4] == 4'h0 && lcsi_in[3:2] == 2'h3) |=> life_class_out == LC_TERM)
    else $error("termination state");
  // status and read parameters
  status_name_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (status_req_in && p1_ok && cmd_in.p2 == P2_NAME) |=> status_rsp_out == RSP_NAME && status_word_out == SW_OK)
    else $error("name response");
  status_p2_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (status_req_in && cmd_in.p2 != P2_FCP && cmd_in.p2 != P2_NAME && cmd_in.p2 != P2_NODATA) |=>
    status_rsp_out == RSP_ERR && !app_activated_out && !app_terminating_out) else $error("reserved p2 accepted");
  read_sref_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (read_req_in && read_allowed_in && cmd_in.p1[7:5] == 3'h4) |=> read_go_out && read_by_sref_out &&
    read_offset_out == {7'h00, $past(cmd_in.p2)} && read_sref_out == $past(cmd_in.p1[4:0]))
    else $error("read by reference");
  read_form_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (read_req_in && cmd_in.p1[7] && cmd_in.p1[6:5] != 2'h0) |=> !read_go_out && status_word_out == SW_DENIED)
    else $error("reserved read form");
  // object stream
  pin_hdr_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (em_r == EM_IDLE && pin_tmpl_req_in) |=> ##1 obj_byte_out == TAG_PIN_TMPL ##2 obj_byte_out == TAG_PIN_EN)
    else $error("pin template header");
  qual_univ_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (em_r == EM_KEY && step_r == 3'h0 && cur_key == KEY_UNIVERSAL) |-> $past(em_r) == EM_QUAL)
    else $error("universal pin unqualified");
  qual_next_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (em_r == EM_QUAL && step_r == 3'h2) |=> em_r == EM_KEY && step_r == 3'h0) else $error("qualifier not adjacent");
  key_obj_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (em_r == EM_KEY && step_r == 3'h0) |=> obj_byte_out == TAG_KEYREF ##1 obj_byte_out == LEN_ONE)
    else $error("key reference object");
  cov_status_c: cover property (@(posedge clk_in) status_req_in ##1 status_rsp_out == RSP_NAME);
  cov_read_c: cover property (@(posedge clk_in) read_go_out && read_by_sref_out);
  cov_qual_c: cover property (@(posedge clk_in) em_r == EM_QUAL);
  cov_term_c: cover property (@(posedge clk_in) life_class_out == LC_TERM);
  cov_deny_c: cover property (@(posedge clk_in) read_req_in && !read_allowed_in ##1 status_word_out == SW_DENIED);
endmodule // fattr_status_dec

/* File: sim/term_model.sv */
// terminal model: issues status and binary read commands as one-cycle strobes
// assumes the card samples strobes and header on the rising edge of clk_in
`timescale 1ns/100ps
module term_model
  import fattr_pkg::*;
(
  // clock
  input wire logic clk_in,
  // command strobes towards the card
  output logic status_req_out,
  output logic read_req_out,
  output cmd_t cmd_out
);
  //==========================================================
  // idle state
  initial begin
    status_req_out = 1'b0;
    read_req_out = 1'b0;
    cmd_out = '{p1: 8'hFF, p2: 8'hFF, le: 8'hFF};
  end
  // one command, held for exactly one edge; header inverted afterwards so stale values never pass
  task automatic issue(input logic is_read, input logic [7:0] p1, input logic [7:0] p2, input logic [7:0] le);
    @(posedge clk_in);
    status_req_out <= !is_read;
    read_req_out <= is_read;
    cmd_out <= '{p1: p1, p2: p2, le: le};
    @(posedge clk_in);
    status_req_out <= 1'b0;
    read_req_out <= 1'b0;
    cmd_out <= cmd_t'(~cmd_out);
  endtask
endmodule // term_model

/* File: sim/fattr_status_dec_bench.sv */
// self-checking bench for the file attribute / status decoder
// assumes the design package and the terminal model are compiled first
`timescale 1ns/100ps
module fattr_status_dec_bench
  import fattr_pkg::*;
;
  //==========================================================
  // stimulus and observed signals
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [15:0] file_id_in = 16'h3F2B;
  logic sref_present_in = 1'b0;
  logic [7:0] sref_len_in = 8'h00;
  logic [7:0] sref_val_in = 8'h00;
  logic [7:0] lcsi_in = 8'h00;
  logic [7:0] pin_enable_map_in = 8'h03;
  logic [3:0] pin_count_in = 4'h2;
  logic [63:0] pin_keys_in = 64'h0000_0000_0000_0111;
  logic [7:0] pin_verify_in = 8'h01;
  logic pin_tmpl_req_in = 1'b0;
  logic life_req_in = 1'b0;
  logic read_allowed_in = 1'b1;
  logic status_req_in, read_req_in;
  cmd_t cmd_in;
  logic [4:0] short_file_ref_out, read_sref_out;
  logic sref_supported_out, sref_malformed_out, app_activated_out, app_terminating_out, done_out;
  life_t life_class_out;
  rsp_t status_rsp_out;
  logic [15:0] status_word_out;
  logic read_go_out, read_by_sref_out, obj_valid_out;
  logic [14:0] read_offset_out;
  logic [7:0] read_len_out, obj_byte_out, pin_enabled_out;
  int n_mismatch = 0;
  int num_checks = 0;
  fattr_status_dec u_fattr_status_dec (.clk_in, .rstn_in, .file_id_in, .sref_present_in, .sref_len_in,
    .sref_val_in, .lcsi_in, .pin_enable_map_in, .pin_count_in, .pin_keys_in, .pin_verify_in, .status_req_in,
    .read_req_in, .pin_tmpl_req_in, .life_req_in, .cmd_in, .read_allowed_in, .short_file_ref_out,
    .sref_supported_out, .sref_malformed_out, .life_class_out, .app_activated_out, .app_terminating_out,
    .status_rsp_out, .status_word_out, .done_out, .read_go_out, .read_offset_out, .read_len_out,
    .read_by_sref_out, .read_sref_out, .obj_byte_out, .obj_valid_out, .pin_enabled_out);
  term_model u_term_model (.clk_in(clk_in), .status_req_out(status_req_in), .read_req_out(read_req_in),
    .cmd_out(cmd_in));
  //==========================================================
  // helpers
  initial begin
    forever #25 clk_in = ~clk_in;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // byte stream capture, starting in the time step of the request's closing edge
  task automatic grab(output logic [7:0] q [$]);
    q = {};
    repeat (40) begin
      #1;
      if (obj_valid_out === 1'b1) q.push_back(obj_byte_out);
      @(posedge clk_in);
    end
  endtask
  task automatic set_sref(input logic pres, input logic [7:0] len, input logic [7:0] val);
    @(posedge clk_in);
    sref_present_in <= pres;
    sref_len_in <= len;
    sref_val_in <= val;
    @(posedge clk_in);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  //==========================================================
  // scenarios
  task automatic sref_scn();
    set_sref(1'b0, 8'h00, 8'h00);
    chk("ref from id", 16'h000B, 16'(short_file_ref_out));
    chk("ref supported", 16'h0001, 16'(sref_supported_out));
    set_sref(1'b1, 8'h00, 8'h00);
    chk("empty object", 16'h0000, 16'(sref_supported_out));
    set_sref(1'b1, 8'h01, 8'hA8);
    chk("ref from value", 16'h0015, 16'(short_file_ref_out));
    chk("clean value", 16'h0000, 16'(sref_malformed_out));
    set_sref(1'b1, 8'h01, 8'hAD);
    chk("low bits set", 16'h0001, 16'(sref_malformed_out));
  endtask
  task automatic life_scn();
    logic [7:0] v [10] = '{8'h00, 8'h01, 8'h03, 8'h05, 8'h07, 8'h04, 8'h0C, 8'h0F, 8'h10, 8'h02};
    life_t c [10] = '{LC_NOINFO, LC_CREATE, LC_INIT, LC_OP_ACT, LC_OP_ACT, LC_OP_DEACT, LC_TERM, LC_TERM,
      LC_PROP, LC_RFU};
    foreach (v[i]) begin
      @(posedge clk_in);
      lcsi_in <= v[i];
      @(posedge clk_in);
      #1;
      chk("life class", 16'(c[i]), 16'(life_class_out));
    end
  endtask
  task automatic status_scn();
    logic [7:0] p1s [3] = '{P1_NONE, P1_ACTIVATED, P1_TERMINATE};
    logic [7:0] p2s [3] = '{P2_FCP, P2_NAME, P2_NODATA};
    rsp_t rs [3] = '{RSP_FCP, RSP_NAME, RSP_NONE};
    logic [7:0] bad1 [2] = '{8'h03, P1_ACTIVATED};
    logic [7:0] bad2 [2] = '{P2_FCP, 8'h02};
    foreach (p1s[i]) begin
      foreach (p2s[j]) begin
        u_term_model.issue(1'b0, p1s[i], p2s[j], (j == 1) ? 8'h20 : 8'h00);
        #1;
        chk("status rsp", 16'(rs[j]), 16'(status_rsp_out));
        chk("status word", SW_OK, status_word_out);
        chk("done", 16'h0001, 16'(done_out));
        chk("activated", 16'(i == 1), 16'(app_activated_out));
        chk("terminating", 16'(i == 2), 16'(app_terminating_out));
      end
    end
    // reserved values must leave both indications quiet
    foreach (bad1[k]) begin
      u_term_model.issue(1'b0, bad1[k], bad2[k], 8'h00);
      #1;
      chk("reserved rsp", 16'(RSP_ERR), 16'(status_rsp_out));
      chk("reserved word", SW_BAD_PARAM, status_word_out);
      chk("reserved pulse", 16'h0000, 16'({app_activated_out, app_terminating_out}));
    end
  endtask
  task automatic rd(input logic ok, input logic [7:0] p1, input logic [7:0] p2, input logic [7:0] le,
      input logic go, input logic bysref, input logic [14:0] off, input logic [4:0] sr);
    @(posedge clk_in);
    read_allowed_in <= ok;
    u_term_model.issue(1'b1, p1, p2, le);
    #1;
    chk("read go", 16'(go), 16'(read_go_out));
    if (go) begin
      chk("read offset", 16'(off), 16'(read_offset_out));
      chk("read len", 16'(le), 16'(read_len_out));
      chk("read by ref", 16'(bysref), 16'(read_by_sref_out));
      if (bysref) chk("read ref", 16'(sr), 16'(read_sref_out));
    end else begin
      chk("read refused", SW_DENIED, status_word_out);
    end
  endtask
  task automatic obj_scn();
    logic [7:0] q [$];
    logic [7:0] pin [$] = '{TAG_PIN_TMPL, 8'h0C, TAG_PIN_EN, LEN_ONE, 8'h03, TAG_QUAL, LEN_ONE, QUAL_VERIFY,
      TAG_KEYREF, LEN_ONE, KEY_UNIVERSAL, TAG_KEYREF, LEN_ONE, 8'h01};
    @(posedge clk_in);
    life_req_in <= 1'b1;
    @(posedge clk_in);
    life_req_in <= 1'b0;
    grab(q);
    chk("life obj size", 16'd3, 16'(q.size()));
    if (q.size() == 3) chk("life obj", {TAG_LIFE, LEN_ONE}, {q[0], q[1]});
    if (q.size() == 3) chk("life obj value", 16'(lcsi_in), 16'(q[2]));
    @(posedge clk_in);
    pin_tmpl_req_in <= 1'b1;
    @(posedge clk_in);
    pin_tmpl_req_in <= 1'b0;
    grab(q);
    chk("pin obj size", 16'(pin.size()), 16'(q.size()));
    // length byte: bitmap object plus a qualifier, a qualified key and a bare key, three bytes each
    foreach (pin[i]) begin
      if (i < q.size()) chk("pin obj byte", 16'(pin[i]), 16'(q[i]));
    end
    chk("pin enabled", 16'h0003, 16'(pin_enabled_out));
  endtask
  //==========================================================
  // main sequence and watchdog
  initial begin
    repeat (10) @(posedge clk_in);
    chk("reset word", SW_OK, status_word_out);
    rstn_in <= 1'b1;
    sref_scn();
    life_scn();
    status_scn();
    rd(1'b1, 8'h12, 8'h34, 8'h10, 1'b1, 1'b0, 15'h1234, 5'h00);
    rd(1'b1, 8'h7F, 8'hFF, 8'h01, 1'b1, 1'b0, 15'h7FFF, 5'h00);
    rd(1'b1, 8'h85, 8'h20, 8'hFF, 1'b1, 1'b1, 15'h0020, 5'h05);
    rd(1'b0, 8'h12, 8'h34, 8'h10, 1'b0, 1'b0, 15'h0000, 5'h00);
    rd(1'b1, 8'hA0, 8'h00, 8'h10, 1'b0, 1'b0, 15'h0000, 5'h00);
    obj_scn();
    tally_and_finish();
  end
  initial begin
    #(50 * 5000);
    n_mismatch++;
    tally_and_finish();
  end
endmodule // fattr_status_dec_bench
